/* File: rtl/annpx_pkg.sv */
// package for the auto-negotiation next-page and expansion status block
// assumes a single 25 MHz register clock and a plain register port
//
// Behaviour
// RQ1 - bit 13 flags message page, code meaning
// RQ2 - unformatted code passes through undecoded
// RQ3 - bit 12 shows partner will comply
// RQ4 - bit 11 shows received alternation bit
// RQ5 - code field read-only, resets to zero
// RQ6 - expansion bits 15:5 read zero, ignore writes
// RQ7 - bit 4 shows parallel detection fault
// RQ8 - bit 3 shows partner next-page support
// RQ9 - bit 2 constant one, local next-page able
// RQ10 - bit 1 page received, clear on read
// RQ11 - bit 0 shows partner autoneg support
// RQ12 - next-page word sits at address 0x05
// RQ13 - new page beats a clearing read
package annpx_pkg;
    // register addresses on the management port
    localparam logic [4:0]  ADDR_NP_WORD   = 5'h05;  // next-page word
    localparam logic [4:0]  ADDR_EXPANSION = 5'h06;  // expansion status
    localparam logic [4:0]  ADDR_IRQ_STAT  = 5'h18;  // sticky events
    localparam logic [4:0]  ADDR_IRQ_MASK  = 5'h19;  // event mask
    // field positions in the next-page word
    localparam int          POS_MSG_PAGE   = 13;
    localparam int          POS_COMPLY     = 12;
    localparam int          POS_TOGGLE     = 11;
    // field positions in the expansion register
    localparam int          POS_PDF        = 4;
    localparam int          POS_LP_NP      = 3;
    localparam int          POS_LOC_NP     = 2;
    localparam int          POS_PAGE_RX    = 1;
    localparam int          POS_LP_AN      = 0;
    // event bit positions in status and mask
    localparam int          EV_PAGE        = 0;
    localparam int          EV_FAULT       = 1;
    localparam int          EV_NUM         = 2;
    // values after reset
    localparam logic [15:0] RST_WORD       = 16'h0000;
    localparam logic [10:0] RST_CODE       = 11'h000;
    localparam logic        LOC_LOCAL_NEXT_PAGE_CAPABLE    = 1'b1;
    localparam logic [1:0]  RST_EVENTS     = 2'h0;

    // next page captured from the partner
    typedef struct packed {
        logic        next_page;
        logic        ack;
        logic        message_page_flag;
        logic        partner_will_comply;
        logic        toggle;
        logic [10:0] code;
    } annpx_page_t;

    // status levels from the negotiation engine
    typedef struct packed {
        logic parallel_detect_fault;
        logic partner_next_page_capable;
        logic partner_autoneg_capable;
    } annpx_link_t;
endpackage

/* File: rtl/annpx_regs.sv */
// register bank: received next-page word and expansion status
// assumes page and link inputs come from logic on REF_CLK_I

`timescale 1ns/1ps

module annpx_regs (
    input  wire logic                  REF_CLK_I,     // 25 MHz clock
    input  wire logic                  RST_I,         // async, high
    input  wire logic [4:0]            ADDR_I,        // register address
    input  wire logic [15:0]           WDATA_I,       // write data
    input  wire logic                  WR_I,          // write strobe
    input  wire logic                  RD_I,          // read strobe
    input  wire annpx_pkg::annpx_page_t PAGE_I,       // received page
    input  wire logic                  PAGE_VALID_I,  // page strobe
    input  wire annpx_pkg::annpx_link_t LINK_I,       // link levels
    output logic [15:0]                RDATA_O,       // read data
    output logic                       IRQ_O          // interrupt level
);

    // stored state
    annpx_pkg::annpx_page_t page_q;      // last received page
    annpx_pkg::annpx_link_t link_q;      // registered link levels
    logic                   page_rx_q;   // clear-on-read flag
    logic [1:0]             ev_stat_q;   // sticky events
    logic [1:0]             ev_mask_q;   // event enables
    logic                   fault_q;     // fault level, last cycle
    logic [15:0]            rdata_q;     // read data register
    logic                   irq_q;       // interrupt register

    // decode wires
    wire rd_word   = RD_I && (ADDR_I == annpx_pkg::ADDR_NP_WORD);
    wire rd_exp    = RD_I && (ADDR_I == annpx_pkg::ADDR_EXPANSION);
    wire wr_stat   = WR_I && (ADDR_I == annpx_pkg::ADDR_IRQ_STAT);
    wire wr_mask   = WR_I && (ADDR_I == annpx_pkg::ADDR_IRQ_MASK);
    wire fault_new = LINK_I.parallel_detect_fault && !fault_q;
    wire [1:0] ev_in = {fault_new, PAGE_VALID_I};

    // page word: code passed as received, never decoded   [RQ1] [RQ2]
    wire [15:0] word_view = page_q;  // [RQ3] [RQ4] [RQ12]

    // expansion view, upper bits tied to zero   [RQ6] [RQ9]
    wire [15:0] exp_view = {11'h000,
                            link_q.parallel_detect_fault,    // [RQ7]
                            link_q.partner_next_page_capable, // [RQ8]
                            annpx_pkg::LOC_LOCAL_NEXT_PAGE_CAPABLE,
                            page_rx_q,
                            link_q.partner_autoneg_capable}; // [RQ11]

    // read multiplexer, unmapped addresses read zero
    wire [15:0] rd_mux =
        (ADDR_I == annpx_pkg::ADDR_NP_WORD)   ? word_view :
        (ADDR_I == annpx_pkg::ADDR_EXPANSION) ? exp_view :
        (ADDR_I == annpx_pkg::ADDR_IRQ_STAT)  ? {14'h0000, ev_stat_q} :
        (ADDR_I == annpx_pkg::ADDR_IRQ_MASK)  ? {14'h0000, ev_mask_q} :
                                                16'h0000;

    // next values
    wire       page_rx_d = PAGE_VALID_I || (page_rx_q && !rd_exp);
    wire [1:0] stat_d    = ev_in | (ev_stat_q &
                                    ~(wr_stat ? WDATA_I[1:0] : 2'h0));
    wire       irq_d     = |(stat_d & ev_mask_q);

    // capture the page, read-only, zero until first page   [RQ5]
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            page_q <= annpx_pkg::RST_WORD;
        end else if (PAGE_VALID_I) begin
            page_q <= PAGE_I;
        end
    end

    // link levels follow the engine
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            link_q  <= '0;
            fault_q <= 1'b0;
        end else begin
            link_q  <= LINK_I;
            fault_q <= LINK_I.parallel_detect_fault;
        end
    end

    // page flag: arrival wins over clearing read   [RQ10] [RQ13]
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            page_rx_q <= 1'b0;
        end else begin
            page_rx_q <= page_rx_d;
        end
    end

    // sticky events, write one clears, set wins
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ev_stat_q <= annpx_pkg::RST_EVENTS;
            ev_mask_q <= annpx_pkg::RST_EVENTS;
        end else begin
            ev_stat_q <= stat_d;
            if (wr_mask) begin
                ev_mask_q <= WDATA_I[1:0];
            end
        end
    end

    // read data and interrupt registers
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_q <= 16'h0000;
            irq_q   <= 1'b0;
        end else begin
            rdata_q <= RD_I ? rd_mux : 16'h0000;
            irq_q   <= irq_d;
        end
    end

    assign RDATA_O = rdata_q;
    assign IRQ_O   = irq_q;

    // assertions: all gathered below the logic they guard, each samples on the
    // register clock and stays quiet while reset is high

    // a page strobe from the negotiation engine
    sequence s_page_arrives;
        PAGE_VALID_I;
    endsequence

    // a read strobe aimed at the next-page word
    sequence s_word_read;
        rd_word;
    endsequence

    // a read strobe aimed at the expansion register
    sequence s_exp_read;
        rd_exp;
    endsequence

    // a page lands, then software reads the expansion register
    sequence s_page_then_read;
        s_page_arrives ##1 s_exp_read;
    endsequence

    // a clearing read with no page arriving in the same cycle
    sequence s_clear_read;
        rd_exp && !PAGE_VALID_I;
    endsequence

    // message flag of a fresh page comes back on the next word read
    // page is captured one edge on, read data one edge later still
    AST_MSG_PAGE: assert property (@(posedge REF_CLK_I) // [RQ1]
        disable iff (RST_I)
        s_page_arrives ##1 s_word_read |=>
            RDATA_O[13] == $past(PAGE_I.message_page_flag, 2))
        else $error("message page bit wrong");

    // code field is stored exactly as it came off the wire
    // no decoding, whatever the message flag says
    AST_CODE_PASS: assert property (@(posedge REF_CLK_I) // [RQ2]
        disable iff (RST_I)
        s_page_arrives |=>
            page_q.code == $past(PAGE_I.code))
        else $error("code field altered");

    // comply bit of the stored page shows on a word read
    // read data reflect the register as it stood at the strobe
    AST_COMPLY: assert property (@(posedge REF_CLK_I) // [RQ3]
        disable iff (RST_I)
        s_word_read |=>
            RDATA_O[12] == $past(page_q.partner_will_comply))
        else $error("comply bit wrong");

    // alternation bit of the stored page shows on a word read
    // polarity is the partner's, passed through untouched
    AST_TOGGLE: assert property (@(posedge REF_CLK_I) // [RQ4]
        disable iff (RST_I)
        s_word_read |=>
            RDATA_O[11] == $past(page_q.toggle))
        else $error("toggle bit wrong");

    // stored page only moves on a page strobe
    // guards against a write path sneaking into the word
    AST_CODE_HOLD: assert property (@(posedge REF_CLK_I) // [RQ5]
        disable iff (RST_I)
        !PAGE_VALID_I |=>
            $stable(page_q))
        else $error("page word changed without page");

    // upper expansion bits read zero, local ability bit reads one
    // both are wired constants in the read view
    AST_RSVD_ZERO: assert property (@(posedge REF_CLK_I) // [RQ6]
        disable iff (RST_I)
        s_exp_read |=>
            RDATA_O[15:5] == 11'h000 && RDATA_O[2])
        else $error("expansion fixed bits wrong");

    // a fault level one cycle before the read is reported
    // link levels are registered, so they lag by one cycle
    AST_FAULT: assert property (@(posedge REF_CLK_I) // [RQ7]
        disable iff (RST_I)
        LINK_I.parallel_detect_fault ##1 s_exp_read |=>
            RDATA_O[4])
        else $error("fault bit not reported");

    // no fault level one cycle before the read reads as zero
    // catches a fault bit stuck high
    AST_FAULT_CLEAR: assert property (@(posedge REF_CLK_I) // [RQ7]
        disable iff (RST_I)
        !LINK_I.parallel_detect_fault ##1 s_exp_read |=>
            !RDATA_O[4])
        else $error("fault bit set without fault");

    // partner next-page ability follows the engine's level
    // two cycles back from the read data: register then read
    AST_LP_NP: assert property (@(posedge REF_CLK_I) // [RQ8]
        disable iff (RST_I)
        s_exp_read |=>
            RDATA_O[3] == $past(LINK_I.partner_next_page_capable, 2))
        else $error("partner next page bit wrong");

    // local next-page ability is a fixed one
    // nothing in this block can send fewer pages
    AST_LOC_NP: assert property (@(posedge REF_CLK_I) // [RQ9]
        disable iff (RST_I)
        s_exp_read |=>
            RDATA_O[2] == 1'b1)
        else $error("local next page bit not one");

    // second expansion read after a page sees the flag cleared
    // unless another page slipped in beside the first read
    AST_COR: assert property (@(posedge REF_CLK_I) // [RQ10]
        disable iff (RST_I)
        s_page_then_read ##1 s_clear_read |=>
            !RDATA_O[1] || $past(PAGE_VALID_I, 2))
        else $error("page flag not cleared by read");

    // a page strobe always leaves the flag set
    // whatever software does in the same cycle
    AST_PAGE_SET: assert property (@(posedge REF_CLK_I) // [RQ10]
        disable iff (RST_I)
        s_page_arrives |=>
            page_rx_q)
        else $error("page flag not set by page");

    // a clearing read with no new page drops the flag
    // checks the flag register itself, not the read view
    AST_FLAG_CLEAR: assert property (@(posedge REF_CLK_I) // [RQ10]
        disable iff (RST_I)
        s_clear_read |=>
            !page_rx_q)
        else $error("page flag survived clearing read");

    // partner autoneg ability follows the engine's level
    // two cycles back from the read data: register then read
    AST_LP_AN: assert property (@(posedge REF_CLK_I) // [RQ11]
        disable iff (RST_I)
        s_exp_read |=>
            RDATA_O[0] == $past(LINK_I.partner_autoneg_capable, 2))
        else $error("autoneg able bit wrong");

    // the whole stored page answers at the word address
    // no other register may share it
    AST_ADDR: assert property (@(posedge REF_CLK_I) // [RQ12]
        disable iff (RST_I)
        s_word_read |=>
            RDATA_O == $past(page_q))
        else $error("word not at its address");

    // arrival and clearing read together keep the flag
    // losing the arrival would hide a page from software
    AST_SET_WINS: assert property (@(posedge REF_CLK_I) // [RQ13]
        disable iff (RST_I)
        s_page_arrives and s_exp_read |=>
            page_rx_q)
        else $error("arrival lost to clearing read");

    // writes to the word address leave the stored page alone
    // the word is read-only for software
    AST_WORD_RO: assert property (@(posedge REF_CLK_I) // [RQ5]
        disable iff (RST_I)
        WR_I && ADDR_I == annpx_pkg::ADDR_NP_WORD && !PAGE_VALID_I |=>
            $stable(page_q))
        else $error("write reached the page word");

    // an unmasked page event raises the interrupt next cycle
    // skipped while the mask itself is being rewritten
    AST_IRQ: assert property (@(posedge REF_CLK_I)
        disable iff (RST_I)
        PAGE_VALID_I && ev_mask_q[0] && !wr_mask |=>
            IRQ_O)
        else $error("interrupt not raised");

    // interrupt level tracks status and mask at all times
    // mask is taken a cycle back since the output is registered
    AST_IRQ_LEVEL: assert property (@(posedge REF_CLK_I)
        disable iff (RST_I)
        1'b1 |->
            IRQ_O == |(ev_stat_q & $past(ev_mask_q)))
        else $error("interrupt level wrong");

    // a page strobe sets its sticky status bit
    // set beats a clearing write in the same cycle
    AST_STAT_SET: assert property (@(posedge REF_CLK_I)
        disable iff (RST_I)
        s_page_arrives |=>
            ev_stat_q[annpx_pkg::EV_PAGE])
        else $error("page event not recorded");

    // a rising fault level sets its sticky status bit
    // only the edge counts, a steady fault does not re-fire
    AST_FAULT_EVENT: assert property (@(posedge REF_CLK_I)
        disable iff (RST_I)
        fault_new |=>
            ev_stat_q[annpx_pkg::EV_FAULT])
        else $error("fault event not recorded");

    // writing a one clears the page status bit
    // provided no page arrives in that same cycle
    AST_STAT_CLEAR: assert property (@(posedge REF_CLK_I)
        disable iff (RST_I)
        wr_stat && WDATA_I[0] && !PAGE_VALID_I |=>
            !ev_stat_q[annpx_pkg::EV_PAGE])
        else $error("page event not cleared");

    // a mask write lands whole on the next edge
    // both event enables come from the low data bits
    AST_MASK_WRITE: assert property (@(posedge REF_CLK_I)
        disable iff (RST_I)
        wr_mask |=>
            ev_mask_q == $past(WDATA_I[1:0]))
        else $error("mask write lost");

    // read data rest at zero outside the cycle after a read
    // lets a bus that ORs slaves together see nothing stale
    AST_RD_IDLE: assert property (@(posedge REF_CLK_I)
        disable iff (RST_I)
        !RD_I |=>
            RDATA_O == 16'h0000)
        else $error("read data not idle");

    // unmapped addresses answer with zero
    // only the four decoded registers drive read data
    AST_UNMAPPED: assert property (@(posedge REF_CLK_I)
        disable iff (RST_I)
        RD_I && !rd_word && !rd_exp && !wr_stat && !wr_mask &&
        ADDR_I != annpx_pkg::ADDR_IRQ_STAT &&
        ADDR_I != annpx_pkg::ADDR_IRQ_MASK |=>
            RDATA_O == 16'h0000)
        else $error("unmapped read not zero");

endmodule // annpx_regs

/* File: test/annpx_partner.sv */
// partner model: far-end negotiation feeding pages and link levels
// assumes the bench toggles req_i once per page to send
`timescale 1ns/1ps
module annpx_partner (
    input  wire logic              clk_i,   // register clock
    input  wire logic              rst_i,   // async, high
    input  wire logic              req_i,   // toggle sends a page
    input  wire logic [15:0]       word_i,  // page to send
    input  wire logic [2:0]        link_i,  // wanted levels
    output annpx_pkg::annpx_page_t page_o,  // page lines
    output logic                   valid_o, // one-cycle strobe
    output annpx_pkg::annpx_link_t link_o   // level lines
);
    logic req_q;  // last request seen
    // page lines churn outside the strobe so stale data never helps
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_q   <= 1'b0;
            valid_o <= 1'b0;
            page_o  <= '0;
            link_o  <= '0;
        end else begin
            req_q   <= req_i;
            valid_o <= req_i ^ req_q;
            page_o  <= (req_i ^ req_q) ? word_i : ~page_o;
            link_o  <= link_i;
        end
    end
endmodule // annpx_partner

/* File: test/tb.sv */
// testbench: next-page word, expansion status and interrupt registers
// assumes the partner model supplies pages and link levels
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, req = 1'b0;
    logic [4:0]  addr = 5'h00;  // register address
    logic [15:0] wdat = 16'h0000, wd = 16'h0000, rdat, got, w;
    logic [2:0]  lk = 3'h0, l;  // link levels wanted
    logic        irq, pv;
    annpx_pkg::annpx_page_t pg;
    annpx_pkg::annpx_link_t ln;
    integer seed = 32'he1ed9ca8, n_errors = 0, num_checks = 0, cyc = 0;
    annpx_partner ptn (.clk_i(clk), .rst_i(rst), .req_i(req),
        .word_i(wd), .link_i(lk), .page_o(pg), .valid_o(pv), .link_o(ln));
    annpx_regs uut (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
        .WDATA_I(wdat), .WR_I(wr), .RD_I(rd), .PAGE_I(pg),
        .PAGE_VALID_I(pv), .LINK_I(ln), .RDATA_O(rdat), .IRQ_O(irq));
    // 25 MHz clock
    always #20 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            complete_run;
        end
    end
    // verdict and end of run
    task automatic complete_run;
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cmp_word(input logic [15:0] g, e, m);
        num_checks = num_checks + 1;
        if ((g & m) !== (e & m)) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_bit(input logic g, e);
        cmp_word({15'h0000, g}, {15'h0000, e}, 16'h0001);
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [4:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdat;
    endtask
    task automatic send_page(input logic [15:0] p, input logic [2:0] k);
        @(posedge clk);
        req <= ~req;
        wd <= p;
        lk <= k;
        repeat (3) @(posedge clk);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk);
        #1 cmp_bit(irq, e);
    endtask
    // expected expansion word from levels and page flag
    function automatic logic [15:0] exp_an(input logic [2:0] k,
                                           input logic rx);
        return {11'h000, k[2], k[1], 1'b1, rx, k[0]};
    endfunction
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(5'h05); cmp_word(got, 16'h0000, 16'h3fff);
        rd_reg(5'h06); cmp_word(got, 16'h0004, 16'hffff);
        rd_reg(5'h1f); cmp_word(got, 16'h0000, 16'hffff);
        for (int i = 0; i < 40; i++) begin
            w = $random(seed);
            l = $random(seed);
            if (i < 2) w = i ? 16'h0000 : 16'h3fff;
            send_page(w, l);
            wr_reg(5'h05, ~w);
            wr_reg(5'h06, 16'hffff);
            rd_reg(5'h05); cmp_word(got, w, 16'h3fff);
            rd_reg(5'h06); cmp_word(got, exp_an(l, 1'b1), 16'hffff);
            cmp_bit(irq, 1'b0);
            rd_reg(5'h06); cmp_word(got, exp_an(l, 1'b0), 16'hffff);
        end
        // page strobe lands in the cycle of a clearing read
        @(posedge clk);
        req <= ~req;
        wd <= 16'h1234;
        rd_reg(5'h06);
        rd_reg(5'h06); cmp_word(got, exp_an(l, 1'b1), 16'hffff);
        // interrupt raised, masked and cleared
        send_page(16'h0800, 3'h0);
        wr_reg(5'h18, 16'h0003);
        wr_reg(5'h19, 16'h0001);
        irq_is(1'b0);
        send_page(16'h0800, 3'h0);
        irq_is(1'b1);
        wr_reg(5'h18, 16'h0001);
        irq_is(1'b0);
        wr_reg(5'h19, 16'h0002);
        send_page(16'h0000, 3'h4);
        irq_is(1'b1);
        rd_reg(5'h18); cmp_word(got, 16'h0003, 16'h0003);
        wr_reg(5'h18, 16'h0003);
        irq_is(1'b0);
        complete_run;
    end
endmodule // tb
